//--- core/acb_pkg.sv
// Purpose: constants for the converter conversion and bus control block
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes: the analog comparator is outside; this block runs the approximation
package acb_pkg;
  localparam int data_width = 8;
  localparam logic [7:0] result_reset = 8'h00;
  // settle cycles for each comparator trial
  localparam int settle_ns = 500;
  localparam int clk_period_ns = 50;
  localparam int settle_cycles = (settle_ns + clk_period_ns - 1) / clk_period_ns;
  typedef enum logic [1:0] {
    acb_idle = 2'b00,
    acb_arm = 2'b01,
    acb_trial = 2'b11,
    acb_finish = 2'b10
  } acb_state_type;
endpackage : acb_pkg

//--- core/acb_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk_i
// Notes: reset value is a parameter so idle-high strobes stay idle
`timescale 1ns/100ps
module acb_sync
  import acb_pkg::*;
#(
  parameter int width = 1,
  parameter logic [width-1:0] reset_value = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // pins
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] sync_o
);
  logic [width-1:0] stage1;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= reset_value;
      sync_o <= reset_value;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : acb_sync

//--- core/acb_ctrl.sv
// Purpose: successive-approximation control and processor bus interface
// Assumes: comparator output is asynchronous; strobes come from a processor
// Notes: a conversion starts on the rising edge that ends a select and write pulse
`timescale 1ns/100ps
module acb_ctrl
  import acb_pkg::*;
#(
  parameter int width = data_width,
  parameter int settle = settle_cycles
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // processor control pins
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  // comparator: high when input at or above trial code
  input wire logic comp_above_i,
  output logic [width-1:0] trial_code_o,
  // data bus
  output logic [width-1:0] data_o,
  output logic data_oe_o,
  // completion
  output logic conversion_done_n_o
);
  logic [2:0] pins_sync;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic comp_s;
  logic strobe_low;

  // ==========================================================
  // pin synchronisers
  // the comparator shares the sync, so every trial pays two cycles of lag
  acb_sync #(.width(4), .reset_value(4'he)) pin_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({chip_select_n_i, read_n_i, write_n_i, comp_above_i}),
    .sync_o({pins_sync, comp_s})
  );
  assign cs_n_s = pins_sync[2];
  assign rd_n_s = pins_sync[1];
  assign wr_n_s = pins_sync[0];

  // ==========================================================
  // start detection
  // a pulse counts once both select and write were low together
  wire write_active = !cs_n_s && !wr_n_s;
  wire start_pulse = strobe_low && !write_active;
  wire read_active = !cs_n_s && !rd_n_s;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strobe_low <= 1'b0;
    end else begin
      strobe_low <= write_active;
    end
  end

  // ==========================================================
  // approximation sequencer
  acb_state_type state;
  acb_state_type next_state;
  logic [width-1:0] sar;
  logic [width-1:0] bit_mask;
  logic [15:0] wait_cnt;
  logic [width-1:0] result;
  logic done_n;
  // settle below 3 would decide on a comparator value from the old trial
  wire settle_done = (wait_cnt == 16'(settle - 1));
  wire last_bit = bit_mask[0];
  // binary weights
  // msb tried first, so each bit weighs half the one above
  wire [width-1:0] kept = comp_s ? sar : (sar & ~bit_mask);

  // completion and start decodes, shared by the latch, flag and checks
  wire load_result = (state == acb_trial) && (next_state == acb_finish);
  wire arm_next = (next_state == acb_arm);

  always_comb begin
    next_state = state;
    unique case (state)
      acb_idle: if (start_pulse) next_state = acb_arm;
      acb_arm: next_state = acb_trial;
      acb_trial: if (settle_done && last_bit) next_state = acb_finish;
      acb_finish: next_state = acb_idle;
    endcase
    if (start_pulse) next_state = acb_arm;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= acb_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar <= '0;
      bit_mask <= '0;
      wait_cnt <= '0;
    end else if (arm_next) begin
      sar <= {1'b1, {(width-1){1'b0}}};
      bit_mask <= {1'b1, {(width-1){1'b0}}};
      wait_cnt <= '0;
    end else if (state == acb_trial) begin
      if (settle_done) begin
        wait_cnt <= '0;
        sar <= kept | (bit_mask >> 1);
        bit_mask <= bit_mask >> 1;
      end else begin
        wait_cnt <= wait_cnt + 16'h0001;
      end
    end
  end

  // latch on completion
  // an aborted run never reaches finish, so the old result stays
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result <= result_reset;
    end else if (load_result) begin
      result <= kept;
    end
  end

  // completion flag
  // the set wins over a read clear landing in the same cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_n <= 1'b1;
    end else if (load_result) begin
      done_n <= 1'b0;
    end else if (read_active || write_active || arm_next) begin
      done_n <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  // three-state data bus
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= '0;
    end else begin
      data_o <= result;
    end
  end
  assign data_oe_o = read_active;
  assign trial_code_o = sar;
  assign conversion_done_n_o = done_n;

  // ==========================================================
  // checks

  restart_arms_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    start_pulse |=> state == acb_arm) else $error("restart did not rearm");

  arm_to_trial_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_arm && !start_pulse |=> state == acb_trial) else $error("arm did not start trials");

  abort_keeps_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state == acb_trial && start_pulse) |=> $stable(result)) else $error("abort changed result");

  latch_only_done_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $changed(result) |-> $past(state) == acb_trial && state == acb_finish) else $error("stray latch");

  data_follows_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $changed(data_o) |-> $past(state) == acb_finish) else $error("bus data changed outside completion");

  finish_to_idle_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_finish && !start_pulse |=> state == acb_idle) else $error("finish did not return idle");

  bus_release_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    cs_n_s |-> !data_oe_o) else $error("bus driven unselected");

  bus_data_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    data_oe_o && $stable(result) |-> data_o == result) else $error("bus data mismatch");

  done_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_finish |-> !conversion_done_n_o) else $error("done not asserted");

  done_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_arm |-> conversion_done_n_o) else $error("done not cleared on start");

  read_clears_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    read_active && !load_result |=> conversion_done_n_o) else $error("read did not clear done");

  done_holds_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !conversion_done_n_o && !read_active && !write_active && !arm_next |=> !conversion_done_n_o)
    else $error("done dropped without a clear");

  msb_first_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_arm |-> trial_code_o == {1'b1, {(width-1){1'b0}}}) else $error("trial not msb");

  trial_bit_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_trial |-> (trial_code_o & bit_mask) == bit_mask) else $error("trial bit missing");

  trial_low_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state == acb_trial |-> (trial_code_o & (bit_mask - {{(width-1){1'b0}}, 1'b1})) == '0)
    else $error("untried bits set");

  // main scenarios
  conv_done_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) state == acb_finish);
  conv_abort_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) state == acb_trial && start_pulse);
  bus_read_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) data_oe_o && !conversion_done_n_o);
  free_loop_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) !conversion_done_n_o && write_active);
  read_unsel_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i) !rd_n_s && cs_n_s);
endmodule : acb_ctrl

//--- verification/acb_cmp_model.sv
// Purpose: comparator and trial converter in front of the block
// Assumes: level_i is the input already in converter counts
// Notes: answers at once, so settle time only costs cycles
`timescale 1ns/100ps
module acb_cmp_model (
  // trial code and analog level
  input wire logic [7:0] trial_code_i,
  input wire logic [7:0] level_i,
  // comparator
  output logic comp_above_o
);
  // ==========
  // comparison
  // straight binary compare
  assign comp_above_o = (level_i >= trial_code_i);
endmodule : acb_cmp_model

//--- verification/testbench.sv
// Purpose: self-checking bench for the conversion and bus control
// Assumes: settle shortened to 3 cycles, the least that covers the comparator sync lag
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
module testbench;
  import acb_pkg::*;
  logic mclk_i, reset_n_i, cs_n, rd_n, wr_n, comp;
  logic [7:0] trial, data, level;
  logic oe, done_n;
  int fail_count = 0, compares = 0, n;
  acb_ctrl #(.settle(3)) i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
    .read_n_i(rd_n), .write_n_i(wr_n), .comp_above_i(comp), .trial_code_o(trial), .data_o(data),
    .data_oe_o(oe), .conversion_done_n_o(done_n));
  acb_cmp_model i_cmp (.trial_code_i(trial), .level_i(level), .comp_above_o(comp));
  // ==========
  // helpers
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task start;
    @(negedge mclk_i) begin cs_n = 0; wr_n = 0; end
    repeat (2) @(negedge mclk_i);
    cs_n = 1;
    wr_n = 1;
  endtask : start
  task wait_done;
    n = 0;
    while (done_n !== 1'b0 && n < 100) begin @(negedge mclk_i); n++; end
    if (done_n !== 1'b0) begin fail_count++; results(); end
  endtask : wait_done
  // select decoded from address, qualified by read
  task io_read(input logic [7:0] addr, input int wait_states, input logic [7:0] exp);
    @(negedge mclk_i) begin cs_n = ~addr[2]; rd_n = 0; end
    repeat (2 + wait_states) @(negedge mclk_i);
    chk("io_oe", {7'h00, oe}, {7'h00, addr[2]});
    if (addr[2]) chk("io_data", data, exp);
    cs_n = 1;
    rd_n = 1;
    repeat (3) @(negedge mclk_i);
  endtask : io_read
  task read_check(input logic [7:0] exp);
    @(negedge mclk_i) begin cs_n = 0; rd_n = 0; end
    repeat (3) @(negedge mclk_i);
    chk("oe_sel", {7'h00, oe}, 8'h01);
    chk("data", data, exp);
    cs_n = 1;
    rd_n = 1;
    repeat (3) @(negedge mclk_i);
    chk("oe_rel", {7'h00, oe}, 8'h00);
    chk("done_rd", {7'h00, done_n}, 8'h01);
  endtask : read_check
  // ==========
  // scenarios
  task t_convert;
    level = 8'hb6;
    start();
    wait_done();
    chk("done", {7'h00, done_n}, 8'h00);
    read_check(8'hb6);
  endtask : t_convert
  task t_restart;
    level = 8'h11;
    start();
    repeat (5) @(negedge mclk_i);
    chk("abort_keep", data, 8'hb6);
    level = 8'h5a;
    start();
    repeat (6) @(negedge mclk_i);
    chk("mid_keep", data, 8'hb6);
    wait_done();
    read_check(8'h5a);
  endtask : t_restart
  task t_unselected;
    @(negedge mclk_i) rd_n = 0;
    repeat (4) @(negedge mclk_i);
    chk("oe_unsel", {7'h00, oe}, 8'h00);
    rd_n = 1;
  endtask : t_unselected
  // address bit 2 alone selects this converter
  task t_io;
    level = 8'h3c;
    start();
    wait_done();
    io_read(8'h08, 1, 8'h3c);
    chk("io_done_kept", {7'h00, done_n}, 8'h00);
    io_read(8'h04, 1, 8'h3c);
    chk("io_done_rd", {7'h00, done_n}, 8'h01);
  endtask : t_io
  task t_freerun;
    level = 8'h7f;
    n = 0;
    cs_n = 0;
    wr_n = 0;
    for (int i = 0; i < 150; i++) begin
      @(negedge mclk_i);
      if (done_n === 1'b0 && wr_n === 1'b1) n++;
      wr_n = done_n;
    end
    chk("runs", (n >= 3) ? 8'h01 : 8'h00, 8'h01);
    chk("free_data", data, 8'h7f);
    cs_n = 1;
    wr_n = 1;
  endtask : t_freerun
  // ==========
  // clock and main sequence
  initial begin mclk_i = 0; forever #25 mclk_i = ~mclk_i; end
  initial begin
    reset_n_i = 0; cs_n = 1; rd_n = 1; wr_n = 1; level = 8'h00;
    repeat (3) @(negedge mclk_i);
    chk("reset_data", data, 8'h00);
    reset_n_i = 1;
    t_convert();
    t_restart();
    t_unselected();
    t_io();
    t_freerun();
    results();
  end
endmodule : testbench
